// ### core/awr_pkg.sv
package awr_pkg;
    localparam int CLK_PERIOD_NS = 10;
    // host-side strobe timing, figures as printed
    localparam int START_PULSE_WIDTH_NS = 600;
    localparam int START_TO_READ_GAP_NS = 800;
    localparam int EARLY_ACCESS_DELAY_NS = 400;
    localparam int ACQUIRE_GAP_NS = 450;
    // least times round up
    localparam int START_PULSE_CYC =
        (START_PULSE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int READ_GAP_CYC =
        (START_TO_READ_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ACCESS_CYC =
        (EARLY_ACCESS_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ACQUIRE_CYC =
        (ACQUIRE_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 8;
    // flops between a device pin and the host logic
    localparam int SYNC_CYC = 2;
    localparam int DATA_W = 8;
    localparam logic [DATA_W-1:0] RESULT_RST = 8'h00;

    typedef enum logic [2:0] {
        AWR_IDLE = 3'b000,
        AWR_START = 3'b001,
        AWR_GAP = 3'b010,
        AWR_WAIT_DONE = 3'b011,
        AWR_ACCESS = 3'b100,
        AWR_RELEASE = 3'b101,
        AWR_ACQUIRE = 3'b110
    } awr_state_e;
endpackage

// ### core/awr_sync.sv
`timescale 1ns/1ps
`default_nettype none
module awr_sync #(
    parameter int WIDTH = 1
) (
    input wire logic i_clk, // clock
    input wire logic i_rst, // sync reset
    input wire logic [WIDTH-1:0] i_async, // pin level
    output logic [WIDTH-1:0] o_sync // synchronised level
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] next_meta;
    logic [WIDTH-1:0] next_sync;

    always_comb begin
        next_meta = i_async;
        next_sync = meta;
    end

    // reset to all ones: pins idle high
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            meta <= '1;
            o_sync <= '1;
        end else begin
            meta <= next_meta;
            o_sync <= next_sync;
        end
    end
endmodule
`default_nettype wire

// ### core/awr_host.sv
// Function
// R01 - device tracks input during acquisition gap
// R02 - falling start strobe begins conversion
// R03 - start rising latches upper nibble
// R04 - done low with lower nibble latched
// R05 - done falls after internal delay
// R06 - host waits acquisition gap after done
// R07 - result driven while select and read low
// R08 - done released on select/read rising
// R09 - early read ends conversion at once
// R10 - early read: done follows read edges
// R11 - fast sequence 600/800/400 ns
// R12 - stand-alone: each start begins conversion
// R13 - stand-alone: previous result on next start
// R14 - result is straight binary code
// R15 - mode high selects write-read
// R16 - strobes ignored unless select low
// R17 - data bus floats unless select, read low
// R18 - completion delay counted after start rise
`timescale 1ns/1ps
`default_nettype none
module awr_host #(
    parameter int START_CYC = awr_pkg::START_PULSE_CYC,
    parameter int GAP_CYC = awr_pkg::READ_GAP_CYC,
    parameter int ACC_CYC = awr_pkg::ACCESS_CYC,
    parameter int ACQ_CYC = awr_pkg::ACQUIRE_CYC
) (
    input wire logic i_clk, // 100 MHz clock
    input wire logic i_rst, // sync reset, high
    input wire logic i_go, // pulse: request a conversion
    input wire logic i_fast, // 1: early read unless stand-alone, 0: wait for done
    input wire logic i_standalone, // 1: select and read held low
    output logic o_busy, // conversion sequence running
    output logic o_valid, // pulse: o_result new
    output logic [awr_pkg::DATA_W-1:0] o_result, // straight binary
    output logic o_mode, // mode pin
    output logic o_cs_n, // chip select, low active
    output logic o_wr_n, // start strobe, low active
    output logic o_rd_n, // read strobe, low active
    input wire logic i_done_n, // done pin, low active
    input wire logic [awr_pkg::DATA_W-1:0] i_result_bus // data pins
);
    import awr_pkg::*;

    localparam int ACC_HOLD = ACC_CYC + SYNC_CYC;

    // cyc(n) loads n-1 into CNT_W bits; the start pulse must outlast
    // the done synchroniser, or a stale low done would be taken
    if (START_CYC <= SYNC_CYC ||
        START_CYC >= 2**CNT_W ||
        GAP_CYC < 1 ||
        GAP_CYC >= 2**CNT_W ||
        ACC_CYC < 1 ||
        ACC_HOLD >= 2**CNT_W ||
        ACQ_CYC < 1 ||
        ACQ_CYC >= 2**CNT_W) begin : g_bad_cfg
        $error("awr_host: cycle counts out of range");
    end

    function automatic logic [CNT_W-1:0] cyc(input int n);
        return CNT_W'(n - 1);
    endfunction

    logic done_n_s;
    logic [DATA_W-1:0] bus_s;
    logic [DATA_W:0] sync_out;

    // done and data share one synchroniser so they age alike
    awr_sync #(.WIDTH(DATA_W + 1)) u_sync (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_async({i_done_n, i_result_bus}),
        .o_sync(sync_out)
    );
    assign done_n_s = sync_out[DATA_W];
    assign bus_s = sync_out[DATA_W-1:0];

    awr_state_e state, next_state;
    logic [CNT_W-1:0] cnt, next_cnt;
    logic fast, next_fast;
    // sa keeps select and read low after the run
    logic sa, next_sa;
    logic have_prev, next_have_prev;
    logic next_busy, next_valid;
    logic [DATA_W-1:0] next_result;
    logic next_cs_n, next_wr_n, next_rd_n;
    logic next_mode;

    // one sequence at a time; a request while busy is dropped
    always_comb begin
        next_state = state;
        next_cnt = (cnt != '0) ? cnt - CNT_W'(1) : cnt;
        next_fast = fast;
        next_sa = sa;
        next_have_prev = have_prev;
        next_valid = 1'b0;
        next_result = o_result;
        next_cs_n = o_cs_n;
        next_wr_n = o_wr_n;
        next_rd_n = o_rd_n;
        next_mode = 1'b1; // R15
        next_busy = 1'b1;
        unique case (state)
            AWR_IDLE: begin
                next_busy = 1'b0;
                if (i_go) begin
                    next_fast = i_fast;
                    next_sa = i_standalone;
                    // select low with the strobe, in the same cycle, so the strobe is recognised
                    next_cs_n = 1'b0; // R16
                    // stand-alone keeps read low all the time
                    next_rd_n = !i_standalone; // R12
                    next_wr_n = 1'b0; // R02
                    next_cnt = cyc(START_CYC); // R11
                    next_busy = 1'b1;
                    next_state = AWR_START;
                end
            end
            AWR_START: begin
                if (cnt == '0) begin
                    // rising edge latches upper nibble in the device
                    next_wr_n = 1'b1; // R03
                    if (sa) begin
                        // previous result shows on this strobe edge
                        if (have_prev) begin
                            next_result = bus_s; // R13
                            next_valid = 1'b1;
                        end
                        next_have_prev = 1'b1;
                        // wait for done too, so the next start keeps the gap
                        next_state = AWR_WAIT_DONE; // R12
                    end else if (fast) begin
                        next_cnt = cyc(GAP_CYC); // R11
                        next_state = AWR_GAP;
                    end else begin
                        next_state = AWR_WAIT_DONE; // R05
                    end
                end
            end
            AWR_GAP: begin
                if (cnt == '0) begin
                    // read before done cuts the delay short
                    next_rd_n = 1'b0; // R09
                    next_cnt = cyc(ACC_HOLD); // R11
                    next_state = AWR_ACCESS;
                end
            end
            AWR_WAIT_DONE: begin
                // done low: full result latched
                if (!done_n_s) begin
                    if (sa) begin
                        // no read strobe: gap counted from done
                        next_cnt = cyc(ACQ_CYC); // R06
                        next_state = AWR_ACQUIRE;
                    end else begin
                        next_rd_n = 1'b0; // R04 R07
                        next_cnt = cyc(ACC_HOLD);
                        next_state = AWR_ACCESS;
                    end
                end
            end
            AWR_ACCESS: begin
                // two extra cycles cover the data synchroniser
                if (cnt == '0) begin
                    next_state = AWR_RELEASE;
                end
            end
            AWR_RELEASE: begin
                // bus_s lags the pins by SYNC_CYC cycles
                next_result = bus_s; // R14
                next_valid = 1'b1;
                // rising read releases done and floats the bus
                next_rd_n = 1'b1; // R08 R10 R17
                next_cs_n = 1'b1;
                next_cnt = cyc(ACQ_CYC);
                next_state = AWR_ACQUIRE;
            end
            AWR_ACQUIRE: begin
                // gap counted from done/strobe so inputs settle
                if (cnt == '0) begin
                    next_state = AWR_IDLE; // R06 R01
                end
            end
            default: begin
                next_state = AWR_IDLE;
            end
        endcase
    end

    // every output is one of these flops
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state <= AWR_IDLE;
            cnt <= '0;
            fast <= 1'b0;
            sa <= 1'b0;
            have_prev <= 1'b0;
            o_busy <= 1'b0;
            o_valid <= 1'b0;
            o_result <= RESULT_RST;
            o_mode <= 1'b1;
            o_cs_n <= 1'b1;
            o_wr_n <= 1'b1;
            o_rd_n <= 1'b1;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            fast <= next_fast;
            sa <= next_sa;
            have_prev <= next_have_prev;
            o_busy <= next_busy;
            o_valid <= next_valid;
            o_result <= next_result;
            o_mode <= next_mode;
            o_cs_n <= next_cs_n;
            o_wr_n <= next_wr_n;
            o_rd_n <= next_rd_n;
        end
    end
endmodule
`default_nettype wire

// ### test/awr_checker.sv
`timescale 1ns/1ps
`default_nettype none
module awr_checker #(
    parameter int START_CYC = 60,
    parameter int GAP_CYC = 80,
    parameter int ACC_CYC = 40,
    parameter int ACQ_CYC = 45
) (
    input wire logic i_clk, // clock
    input wire logic i_rst, // sync reset
    input wire logic i_go, // request
    input wire logic o_busy, // running
    input wire logic o_valid, // result pulse
    input wire logic o_mode, // mode pin
    input wire logic o_cs_n, // select
    input wire logic o_wr_n, // start strobe
    input wire logic o_rd_n, // read strobe
    input wire logic i_done_n // done pin
);
    int wl;
    int sw;
    int sd;
    // sw and sd saturate at 1000 so idle spans never wrap
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            wl <= 0;
            sw <= 0;
            sd <= 1000;
        end else begin
            wl <= o_wr_n ? 0 : wl + 1;
            sw <= !o_wr_n ? 0 : (sw < 1000 ? sw + 1 : sw);
            sd <= $fell(i_done_n) ? 0 : (sd < 1000 ? sd + 1 : sd);
        end
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    a_mode_high: assert property (o_mode)
        else $error("mode pin low");
    a_start_width: assert property ($rose(o_wr_n) |-> wl == START_CYC)
        else $error("start strobe width wrong");
    a_start_select: assert property (!o_wr_n |-> !o_cs_n)
        else $error("start strobe without select");
    a_read_gap: assert property (
        $fell(o_rd_n) && o_wr_n |-> sw >= GAP_CYC)
        else $error("read too soon after start");
    a_read_select: assert property ($fell(o_rd_n) |-> !o_cs_n)
        else $error("read without select");
    a_acquire_gap: assert property ($fell(o_wr_n) |-> sd >= ACQ_CYC)
        else $error("acquisition gap too short");
    a_go_start: assert property (i_go && !o_busy |=> o_busy && !o_wr_n)
        else $error("request did not start");
    a_valid_once: assert property (o_valid |=> !o_valid)
        else $error("result pulse too long");
    a_select_rise: assert property ($rose(o_cs_n) |-> o_rd_n)
        else $error("select released before read");
endmodule
bind awr_host awr_checker #(.START_CYC(START_CYC), .GAP_CYC(GAP_CYC),
    .ACC_CYC(ACC_CYC), .ACQ_CYC(ACQ_CYC)) u_chk (.i_clk, .i_rst, .i_go,
    .o_busy, .o_valid, .o_mode, .o_cs_n, .o_wr_n, .o_rd_n, .i_done_n);
`default_nettype wire

// ### test/awr_adc_model.sv
`timescale 1ns/1ps
`default_nettype none
module awr_adc_model (
    input wire logic i_clk, // sampling clock
    input wire logic i_mode, // mode pin
    input wire logic i_cs_n, // select
    input wire logic i_wr_n, // start strobe
    input wire logic i_rd_n, // read strobe
    input wire logic [7:0] i_sample, // analog value as code
    input wire logic [7:0] i_delay, // internal finish delay
    output logic o_done_n, // done pin
    output logic [7:0] o_bus // data pins
);
    logic wr_q = 1'b1;
    logic rd_q = 1'b1;
    logic cs_q = 1'b1;
    logic conv = 1'b0;
    logic [7:0] cnt = 8'h00;
    logic [7:0] hold = 8'h00;
    logic [7:0] res = 8'h00;
    initial o_done_n = 1'b1;
    logic rd_fall;
    // early read is an edge: a read held low does not cut the delay
    assign rd_fall = rd_q && !i_rd_n && !i_cs_n;
    always @(posedge i_clk) begin
        wr_q <= i_wr_n;
        rd_q <= i_rd_n;
        cs_q <= i_cs_n;
        if (i_mode && !i_cs_n && wr_q && !i_wr_n) begin
            hold <= i_sample;
            // a new start clears done, as stand-alone use needs
            o_done_n <= 1'b1;
        end
        if (i_mode && !i_cs_n && !wr_q && i_wr_n) begin
            res[7:4] <= hold[7:4];
            conv <= 1'b1;
            cnt <= i_delay;
        end else if (conv && (cnt == 8'h00 || rd_fall)) begin
            res[3:0] <= hold[3:0];
            conv <= 1'b0;
            o_done_n <= 1'b0;
        end else if (conv) begin
            cnt <= cnt - 8'h01;
        end
        if ((!rd_q && i_rd_n) || (!cs_q && i_cs_n)) begin
            o_done_n <= 1'b1;
        end
    end
    // no pull-up: a released bus shows the inverse, not the old byte
    assign o_bus = (!i_cs_n && !i_rd_n) ? res : ~res;
endmodule
`default_nettype wire

// ### test/awr_host_bench.sv
`timescale 1ns/1ps
`default_nettype none
module awr_host_bench;
    logic clk, rst = 1'b1, go = 1'b0, fast = 1'b0, sa = 1'b0;
    logic busy, valid, mode, cs_n, wr_n, rd_n, done_n;
    logic [7:0] result, bus, res, smp = 8'h00;
    int n_fail = 0, n_compared = 0, cyc = 0, nv;
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    awr_host #(.START_CYC(3), .GAP_CYC(4), .ACC_CYC(2), .ACQ_CYC(3)) dut (
        .i_clk(clk), .i_rst(rst), .i_go(go), .i_fast(fast),
        .i_standalone(sa), .o_busy(busy), .o_valid(valid), .o_result(result),
        .o_mode(mode), .o_cs_n(cs_n), .o_wr_n(wr_n), .o_rd_n(rd_n),
        .i_done_n(done_n), .i_result_bus(bus));
    awr_adc_model model (.i_clk(clk), .i_mode(mode), .i_cs_n(cs_n),
        .i_wr_n(wr_n), .i_rd_n(rd_n), .i_sample(smp), .i_delay(8'h0A),
        .o_done_n(done_n), .o_bus(bus));
    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic finish_test;
        $display("compared %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // go stays up a second cycle: that one lands while busy
    task automatic conv(input logic f, input logic s, input logic [7:0] v);
        nv = 0;
        @(posedge clk);
        go <= 1'b1;
        fast <= f;
        sa <= s;
        smp <= v;
        repeat (2) @(posedge clk);
        go <= 1'b0;
        for (int k = 0; k < 2000; k++) begin
            @(posedge clk);
            #1;
            if (valid === 1'b1) begin
                nv++;
                res = result;
            end
            if (busy === 1'b0) break;
        end
        chk("busy end", 8'h00, {7'h00, busy});
    endtask
    task automatic test_fast;
        conv(1'b1, 1'b0, 8'hFF);
        chk("fast count", 8'h01, 8'(nv));
        chk("fast full scale", 8'hFF, res);
        conv(1'b1, 1'b0, 8'h00);
        chk("fast zero", 8'h00, res);
        $display("test_fast done");
    endtask
    task automatic test_normal;
        conv(1'b0, 1'b0, 8'hA5);
        chk("normal count", 8'h01, 8'(nv));
        chk("normal result", 8'hA5, res);
        $display("test_normal done");
    endtask
    task automatic test_standalone;
        conv(1'b0, 1'b1, 8'h3C);
        chk("alone first count", 8'h00, 8'(nv));
        conv(1'b0, 1'b1, 8'hC3);
        chk("alone second count", 8'h01, 8'(nv));
        chk("alone previous", 8'h3C, res);
        $display("test_standalone done");
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            finish_test();
        end
    end
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        test_fast();
        test_normal();
        test_standalone();
        finish_test();
    end
endmodule
`default_nettype wire
